// ---- logic/accum_alu_regs.svh ----
// register offsets, status bit positions, opcode fields and reset values
// assumes a 32-bit AHB-Lite bus with word-aligned accesses
`ifndef ACCUM_ALU_REGS_SVH
`define ACCUM_ALU_REGS_SVH

// =============================================================
// register map (byte offsets within the block, file region select and port file index)
`define OFS_INSTR      12'h000
`define OFS_ACC        12'h004
`define OFS_STATUS     12'h008
`define FILE_REGION    3'h1
`define PORT_ADDR      7'h05

// =============================================================
// status register bit positions
`define STAT_CARRY     0
`define STAT_DIGIT     1
`define STAT_ZERO      2
`define STAT_SKIP      3

// =============================================================
// opcode fields and the bus word size code
`define OPC_CLASS_BYTE 2'h0
`define OPC_CLASS_BIT  2'h1
`define OPC_CLASS_LIT  2'h3
`define OPC_ADD_FILE   4'h7
`define OPC_AND_FILE   4'h5
`define OPC_BIT_CLEAR  2'h0
`define OPC_BIT_SET    2'h1
`define OPC_SKIP_LOW   2'h2
`define OPC_SKIP_HIGH  2'h3
`define OPC_ADD_LIT    3'h7
`define OPC_AND_LIT    4'h9
`define HSIZE_WORD     3'h2

// =============================================================
// reset values
`define ACC_RESET      8'h00
`define FILE_RESET     8'h00

`endif

// ---- logic/accum_alu_pkg.sv ----
// types shared by the execution unit and its datapath
// assumes accum_alu_regs.svh supplies the numeric constants
`default_nettype none
package accum_alu_pkg;

	typedef enum logic [2:0] {
		PH_IDLE    = 3'b001,
		PH_WRITE   = 3'b010,
		PH_RDSTALL = 3'b100
	} busPhase_e;

	typedef struct packed {
		logic c;
		logic dc;
		logic z;
	} flags_s;

	typedef struct packed {
		logic       toAcc;
		logic       toFile;
		logic       updCarry;
		logic       updDigit;
		logic       updZero;
		flags_s     flags;
		logic       skip;
		logic [7:0] value;
	} aluOut_s;

	typedef struct packed {
		busPhase_e        phase;
		logic [11:0]      addr;
		logic [7:0]       acc;
		flags_s           flags;
		logic             skipPend;
		logic [127:0][7:0] file;
		logic [31:0]      rdata;
		logic             ready;
	} state_s;

endpackage
`default_nettype wire

// ---- logic/alu_bit_unit.sv ----
// combinational datapath: decodes one 14-bit instruction word
// assumes the caller has already picked the file operand (pins or latch)
`timescale 1ns/10ps
`default_nettype none
`include "accum_alu_regs.svh"

module alu_bit_unit (
	// instruction and operands
	input  wire logic [13:0]           instr,
	input  wire logic [7:0]            acc,
	input  wire logic [7:0]            operand,
	// result
	output accum_alu_pkg::aluOut_s     res
);

	always_comb begin
		logic [8:0] sum;
		logic [4:0] low;
		logic [7:0] src;
		logic [7:0] mask;
		logic       bitVal;
		res    = '0;
		src    = (instr[13:12] == `OPC_CLASS_LIT) ? instr[7:0] : operand;
		sum    = {1'b0, acc} + {1'b0, src};
		low    = {1'b0, acc[3:0]} + {1'b0, src[3:0]};
		mask   = 8'h01 << instr[9:7];
		bitVal = |(operand & mask);
		case (instr[13:12])
			`OPC_CLASS_BYTE: begin
				case (instr[11:8])
					`OPC_ADD_FILE: begin
						res.value    = sum[7:0];
						res.toAcc    = !instr[7];
						res.toFile   = instr[7];
						res.updCarry = 1'b1;
						res.updDigit = 1'b1;
						res.updZero  = 1'b1;
					end
					`OPC_AND_FILE: begin
						res.value   = acc & operand;
						res.toAcc   = !instr[7];
						res.toFile  = instr[7];
						res.updZero = 1'b1;
					end
					default: ;
				endcase
			end
			`OPC_CLASS_BIT: begin
				case (instr[11:10])
					`OPC_BIT_CLEAR: begin
						res.value  = operand & ~mask;
						res.toFile = 1'b1;
					end
					`OPC_BIT_SET: begin
						res.value  = operand | mask;
						res.toFile = 1'b1;
					end
					`OPC_SKIP_LOW:  res.skip = !bitVal;
					`OPC_SKIP_HIGH: res.skip = bitVal;
					default: ;
				endcase
			end
			`OPC_CLASS_LIT: begin
				if (instr[11:9] == `OPC_ADD_LIT) begin
					res.value    = sum[7:0];
					res.toAcc    = 1'b1;
					res.updCarry = 1'b1;
					res.updDigit = 1'b1;
					res.updZero  = 1'b1;
				end else if (instr[11:8] == `OPC_AND_LIT) begin
					res.value   = acc & src;
					res.toAcc   = 1'b1;
					res.updZero = 1'b1;
				end
			end
			default: ;
		endcase
		res.flags.c  = sum[8];
		res.flags.dc = low[4];
		res.flags.z  = (res.value == 8'h00);
	end

endmodule // alu_bit_unit
`default_nettype wire

// ---- logic/accum_alu_bit_test_exec.sv ----
// execution unit for add, AND, bit set/clear and bit-test-skip
// assumes a single AHB-Lite master; hready is this slave's hreadyout
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "accum_alu_regs.svh"

module accum_alu_bit_test_exec (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// port pins
	input  wire logic [7:0]  portPins,
	output logic [7:0]       portOut
);

	localparam accum_alu_pkg::state_s ST_RESET = '{
		phase:    accum_alu_pkg::PH_IDLE,
		addr:     12'h000,
		acc:      `ACC_RESET,
		flags:    3'h0,
		skipPend: 1'b0,
		file:     {128{`FILE_RESET}},
		rdata:    32'h0000_0000,
		ready:    1'b1
	};

	accum_alu_pkg::state_s  stQ;
	accum_alu_pkg::state_s  stD;
	accum_alu_pkg::aluOut_s aluRes;
	logic [6:0]             fileIdx;
	logic [7:0]             operand;
	logic                   execValid;
	logic                   respQ;

	assign fileIdx = hwdata[6:0];

	// read-modify-write of the port sees the pins, so an input held low
	// by the outside world is written back low
	assign operand = (fileIdx == `PORT_ADDR) ? portPins
	                                         : stQ.file[fileIdx];

	alu_bit_unit datapath (
		.instr   (hwdata[13:0]),
		.acc     (stQ.acc),
		.operand (operand),
		.res     (aluRes)
	);

	// =============================================================
	// register read view
	function automatic logic [31:0] readView(
		input logic [11:0]           a,
		input accum_alu_pkg::state_s s,
		input logic [7:0]            pins
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == `OFS_ACC) begin
			v[7:0] = s.acc;
		end else if (a == `OFS_STATUS) begin
			v[`STAT_CARRY] = s.flags.c;
			v[`STAT_DIGIT] = s.flags.dc;
			v[`STAT_ZERO]  = s.flags.z;
			v[`STAT_SKIP]  = s.skipPend;
		end else if (a[11:9] == `FILE_REGION) begin
			v[7:0] = (a[8:2] == `PORT_ADDR) ? pins : s.file[a[8:2]];
		end
		return v;
	endfunction

	// =============================================================
	// next state
	always_comb begin
		logic accepted;
		stD       = stQ;
		execValid = 1'b0;
		accepted  = hsel && htrans[1] && hready && (hsize == `HSIZE_WORD);
		case (stQ.phase)
			accum_alu_pkg::PH_WRITE: begin
				if (stQ.addr == `OFS_INSTR) begin
					execValid = 1'b1;
					if (stQ.skipPend) begin
						// the discarded instruction becomes the NOP cycle
						stD.skipPend = 1'b0;
					end else begin
						if (aluRes.toAcc) begin
							stD.acc = aluRes.value;
						end
						if (aluRes.toFile) begin
							stD.file[fileIdx] = aluRes.value;
						end
						if (aluRes.updCarry) begin
							stD.flags.c = aluRes.flags.c;
						end
						if (aluRes.updDigit) begin
							stD.flags.dc = aluRes.flags.dc;
						end
						if (aluRes.updZero) begin
							stD.flags.z = aluRes.flags.z;
						end
						stD.skipPend = aluRes.skip;
					end
				end else if (stQ.addr == `OFS_ACC) begin
					stD.acc = hwdata[7:0];
				end else if (stQ.addr == `OFS_STATUS) begin
					stD.flags.c  = hwdata[`STAT_CARRY];
					stD.flags.dc = hwdata[`STAT_DIGIT];
					stD.flags.z  = hwdata[`STAT_ZERO];
				end else if (stQ.addr[11:9] == `FILE_REGION) begin
					stD.file[stQ.addr[8:2]] = hwdata[7:0];
				end
			end
			accum_alu_pkg::PH_RDSTALL: begin
				stD.rdata = readView(stQ.addr, stQ, portPins);
				stD.ready = 1'b1;
			end
			default: ;
		endcase
		stD.phase = accum_alu_pkg::PH_IDLE;
		if (accepted) begin
			stD.addr = haddr[11:0];
			if (hwrite) begin
				stD.phase = accum_alu_pkg::PH_WRITE;
			end else if (stQ.phase == accum_alu_pkg::PH_WRITE) begin
				// one wait state so the read sees the write just done
				stD.phase = accum_alu_pkg::PH_RDSTALL;
				stD.ready = 1'b0;
			end else begin
				stD.rdata = readView(haddr[11:0], stQ, portPins);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stQ   <= ST_RESET;
			respQ <= 1'b0;
		end else begin
			stQ   <= stD;
			respQ <= 1'b0;
		end
	end

	assign hreadyout = stQ.ready;
	assign hresp     = respQ;
	assign hrdata    = stQ.rdata;
	assign portOut   = stQ.file[`PORT_ADDR];

	// =============================================================
	// checks
	logic       doExec;
	logic       isAddLit;
	logic       isAndLit;
	logic       isAddFile;
	logic       isAndFile;
	logic [1:0] bitOp;
	logic       isBitOp;
	logic       bitVal;

	assign doExec    = execValid && !stQ.skipPend;
	assign isAddLit  = hwdata[13:12] == `OPC_CLASS_LIT
	                   && hwdata[11:9] == `OPC_ADD_LIT;
	assign isAndLit  = hwdata[13:12] == `OPC_CLASS_LIT
	                   && hwdata[11:8] == `OPC_AND_LIT;
	assign isAddFile = hwdata[13:12] == `OPC_CLASS_BYTE
	                   && hwdata[11:8] == `OPC_ADD_FILE;
	assign isAndFile = hwdata[13:12] == `OPC_CLASS_BYTE
	                   && hwdata[11:8] == `OPC_AND_FILE;
	assign isBitOp   = hwdata[13:12] == `OPC_CLASS_BIT;
	assign bitOp     = hwdata[11:10];
	assign bitVal    = operand[hwdata[9:7]];

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	addlit_sum_a: assert property (doExec && isAddLit |=>
		stQ.acc == 8'($past(stQ.acc) + $past(hwdata[7:0])))
		else $error("literal add result wrong");

	carry_out_a: assert property (doExec && isAddLit |=>
		stQ.flags.c == ({1'b0, $past(stQ.acc)} + {1'b0, $past(hwdata[7:0])}
		> 9'h0FF) && stQ.flags.z == (stQ.acc == 8'h00))
		else $error("carry or zero wrong after add");

	addfile_dest_a: assert property (doExec && isAddFile && hwdata[7] |=>
		stQ.file[$past(fileIdx)] == 8'($past(stQ.acc) + $past(operand))
		&& $stable(stQ.acc))
		else $error("file add destination wrong");

	andlit_flags_a: assert property (doExec && isAndLit |=>
		stQ.acc == ($past(stQ.acc) & $past(hwdata[7:0]))
		&& $stable(stQ.flags.c) && $stable(stQ.flags.dc))
		else $error("literal AND wrong");

	andfile_acc_a: assert property (doExec && isAndFile && !hwdata[7] |=>
		stQ.acc == ($past(stQ.acc) & $past(operand))
		&& $stable(stQ.flags.dc) && $stable(stQ.file))
		else $error("file AND to accumulator wrong");

	bit_clear_a: assert property (doExec && isBitOp
		&& bitOp == `OPC_BIT_CLEAR |=>
		stQ.file[$past(fileIdx)][$past(hwdata[9:7])] == 1'b0
		&& $stable(stQ.flags))
		else $error("bit clear wrong");

	bit_set_a: assert property (doExec && isBitOp
		&& bitOp == `OPC_BIT_SET |=>
		stQ.file[$past(fileIdx)][$past(hwdata[9:7])] == 1'b1
		&& $stable(stQ.flags))
		else $error("bit set wrong");

	skip_low_a: assert property (doExec && isBitOp
		&& bitOp == `OPC_SKIP_LOW |=>
		stQ.skipPend == !$past(bitVal) && $stable(stQ.flags))
		else $error("skip on low bit wrong");

	skip_high_a: assert property (doExec && isBitOp
		&& bitOp == `OPC_SKIP_HIGH |=>
		stQ.skipPend == $past(bitVal) && $stable(stQ.acc))
		else $error("skip on high bit wrong");

	skip_discard_a: assert property (execValid && stQ.skipPend |=>
		!stQ.skipPend && $stable(stQ.acc) && $stable(stQ.flags)
		&& $stable(stQ.file))
		else $error("skipped instruction was not discarded");

	pin_source_a: assert property (doExec && isAndFile && !hwdata[7]
		&& fileIdx == `PORT_ADDR |=>
		stQ.acc == ($past(stQ.acc) & $past(portPins)))
		else $error("port operand not taken from pins");

endmodule // accum_alu_bit_test_exec
`default_nettype wire

// ---- sim/accum_alu_bit_test_exec_test.sv ----
// self-checking bench for the accumulator execution unit
// assumes the logic/ design files; bench is the only bus master
`timescale 1ns/10ps
`default_nettype none
`include "accum_alu_regs.svh"

module accum_alu_bit_test_exec_test;
	// ==========================================================
	// signals
	logic        clk;
	logic        reset;
	logic        hsel;
	logic        hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  portPins;
	logic [7:0]  portOut;
	int          n_mismatch;
	int          samples_checked;
	int          cycles;
	int          i;
	int          b;
	int          op;
	logic [31:0] rd;
	logic [7:0]  v;
	logic        taken;
	logic [7:0]  tA [4] = '{8'h0F, 8'h01, 8'h80, 8'h12};
	logic [7:0]  tK [4] = '{8'h01, 8'hFF, 8'h80, 8'h34};
	localparam logic [31:0] insA = {20'h0, `OFS_INSTR};
	localparam logic [31:0] accA = {20'h0, `OFS_ACC};
	localparam logic [31:0] stA  = {20'h0, `OFS_STATUS};

	accum_alu_bit_test_exec uut (
		.clk      (clk),
		.reset    (reset),
		.hsel     (hsel),
		.haddr    (haddr),
		.htrans   (htrans),
		.hwrite   (hwrite),
		.hsize    (hsize),
		.hwdata   (hwdata),
		.hready   (hreadyout),
		.hreadyout(hreadyout),
		.hresp    (hresp),
		.hrdata   (hrdata),
		.portPins (portPins),
		.portOut  (portOut)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================================
	// tasks
	task report_and_stop;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under 2000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task rdc(input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	task ex(input logic [13:0] ins);
		wr(insA, {18'h0, ins});
	endtask

	function automatic logic [31:0] fA(input logic [6:0] f);
		return 32'h200 + {23'h0, f, 2'b00};
	endfunction

	// status word {skip, zero, digit carry, carry} after an add
	function automatic logic [31:0] addSt(input logic [7:0] a, k);
		logic [8:0] s;
		logic [4:0] n;
		s = {1'b0, a} + {1'b0, k};
		n = {1'b0, a[3:0]} + {1'b0, k[3:0]};
		return {29'h0, s[7:0] == 8'h00, n[4], s[8]};
	endfunction

	// ==========================================================
	// sequence
	initial begin
		reset = 1'b1;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = `HSIZE_WORD;
		haddr = 32'h0;
		hwdata = 32'h0;
		portPins = 8'h00;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rdc(accA, 32'h0);
		rdc(stA, 32'h0);
		check({24'h0, portOut}, 32'h0);
		check({31'h0, hresp}, 32'h0);
		check({31'h0, hreadyout}, 32'h1);
		for (i = 0; i < 4; i++) begin
			wr(accA, {24'h0, tA[i]});
			wr(stA, 32'h0);
			ex({6'h3E, tK[i]});
			rdc(accA, {24'h0, tA[i] + tK[i]});
			rdc(stA, addSt(tA[i], tK[i]));
		end
		wr(stA, 32'h3);
		wr(accA, 32'hF0);
		ex({6'h39, 8'h0F});
		rdc(accA, 32'h0);
		rdc(stA, 32'h7);
		wr(accA, 32'h3C);
		ex({6'h39, 8'hFF});
		rdc(stA, 32'h3);
		wr(fA(7'h7F), 32'h88);
		wr(accA, 32'h88);
		wr(stA, 32'h0);
		ex({2'h0, 4'h7, 1'b0, 7'h7F});
		rdc(accA, 32'h10);
		rdc(stA, 32'h3);
		rdc(fA(7'h7F), 32'h88);
		ex({2'h0, 4'h7, 1'b1, 7'h7F});
		rdc(fA(7'h7F), 32'h98);
		rdc(accA, 32'h10);
		rdc(stA, 32'h0);
		wr(stA, 32'h3);
		wr(accA, 32'h67);
		ex({2'h0, 4'h5, 1'b1, 7'h7F});
		rdc(fA(7'h7F), 32'h0);
		rdc(stA, 32'h7);
		wr(fA(7'h7F), 32'hF1);
		ex({2'h0, 4'h5, 1'b0, 7'h7F});
		rdc(accA, 32'h61);
		rdc(stA, 32'h3);
		v = 8'h00;
		wr(stA, 32'h5);
		for (b = 0; b < 16; b++) begin
			ex({2'h1, 1'b0, b < 8, b[2:0], 7'h20});
			v[b[2:0]] = b < 8;
			rdc(fA(7'h20), {24'h0, v});
		end
		rdc(stA, 32'h5);
		for (i = 0; i < 4; i++) begin
			op = 2 + i / 2;
			taken = (op == 2) ? (i % 2 == 0) : (i % 2 == 1);
			wr(fA(7'h20), {28'h0, i[0], 3'h0});
			wr(accA, 32'h1);
			wr(stA, 32'h7);
			ex({2'h1, op[1:0], 3'h3, 7'h20});
			rdc(stA, {28'h0, taken, 3'h7});
			ex({6'h3E, 8'h01});
			rdc(accA, taken ? 32'h1 : 32'h2);
			rdc(stA, taken ? 32'h7 : 32'h0);
		end
		wr(fA(`PORT_ADDR), 32'hF0);
		// the latch moves at the write's closing edge: look one edge later
		@(posedge clk);
		check({24'h0, portOut}, 32'hF0);
		portPins <= 8'h0F;
		rdc(fA(`PORT_ADDR), 32'h0F);
		ex({2'h1, 2'h1, 3'h7, `PORT_ADDR});
		@(posedge clk);
		check({24'h0, portOut}, 32'h8F);
		wr(stA, 32'h0);
		ex({2'h1, 2'h2, 3'h7, `PORT_ADDR});
		rdc(stA, 32'h8);
		ex(14'h0);
		wr(accA, 32'h1);
		ex({2'h0, 4'h7, 1'b0, `PORT_ADDR});
		rdc(accA, 32'h10);
		// pins 0x0F against latch 0x8F: only the pin value gives 0x0F
		wr(accA, 32'hFF);
		ex({2'h0, 4'h5, 1'b0, `PORT_ADDR});
		rdc(accA, 32'h0F);
		wr(32'h100, 32'hFFFFFFFF);
		rdc(32'h100, 32'h0);
		report_and_stop();
	end
endmodule // accum_alu_bit_test_exec_test

`default_nettype wire
